// ===== hdl/interrupt_source_vectoring.sv
/*
  Interrupt source, priority and vector logic with an APB register slave.
  Assumes pins are asynchronous to core_clk, on-chip module requests arrive
  already gated by their own enables on core_clk, and the CPU core pulses
  cpu_ack with the vector it has taken.
  Request pins idle high, and their synchronisers reset to that level.
  The picker between the state and the offer is combinational.
*/
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module interrupt_source_vectoring (
  input logic core_clk,
  input logic rst_b,
  input logic nmi_pin,
  input logic [vectoring_pkg::NUM_EXT-1:0] ext_request_b,
  input logic [vectoring_pkg::NUM_INT-1:0] module_req,
  input logic cpu_ack,
  input logic [vectoring_pkg::VEC_W-1:0] ack_vector,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [vectoring_pkg::ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_valid,
  output logic [vectoring_pkg::VEC_W-1:0] irq_vector,
  output logic [15:0] irq_vector_addr,
  output logic irq_level,
  output logic wake_request
);
  import vectoring_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic nmi_s1;                 // Pin synchroniser, first stage
    logic nmi_s2;                 // Pin synchroniser, second stage
    logic nmi_prev;               // Previous synchronised level
    logic [NUM_EXT-1:0] ext_s1;   // Request pin synchroniser, first stage
    logic [NUM_EXT-1:0] ext_s2;   // Request pin synchroniser, second stage
    logic [NUM_EXT-1:0] ext_prev; // Previous synchronised levels
    logic nmi_pend;               // Non-maskable request waiting
    logic [NUM_EXT-1:0] flag;     // request_status_flag bits
    logic [NUM_EXT-1:0] seen;     // Flag has been read as one
    logic [1:0] sys_ctrl;         // system_control_reg fields
    logic [7:0] sense;            // request_sense_select_reg
    logic [NUM_EXT-1:0] enable;   // request_enable_reg fields
    logic [7:0] prio_a;           // priority_reg_a
    logic [7:0] prio_b;           // priority_reg_b
    logic pready;                 // APB answer
    logic [31:0] prdata;          // APB read data
    logic pslverr;                // APB error
    logic irq_valid;              // A request is offered to the CPU
    logic [VEC_W-1:0] vector;     // Offered vector number
    logic [15:0] vec_addr;        // Offered vector address
    logic level;                  // Offered priority level
    logic wake;                   // Standby exit request
  } state_t;

  // Reset state: request synchronisers start at the idle high level, so
  // level sensing cannot latch a false request while they fill
  localparam state_t RESET_ST = '{ext_s1: '1, ext_s2: '1, ext_prev: '1, default: '0};

  state_t st;            // Registered state
  state_t next_st;       // Next state
  rank_if rk ();         // Link to the picker

  logic access;                   // APB access phase
  logic done;                     // APB transfer completes this edge
  logic mapped;                   // Address decodes to a register
  logic wr_done;                  // Completing write to a mapped register
  logic [7:0] rd_mux;             // Selected register read value
  logic [NUM_EXT-1:0] fwd_ext;    // Enabled external requests
  logic [15:0] prio_all;          // Both priority registers
  logic [NUM_EXT-1:0] ext_set;    // External flag set condition
  logic nmi_edge;                 // Selected non-maskable edge seen

  source_ranker #(.N(NUM_SRC)) u_ranker (.rk(rk));

  // APB decode; a transfer completes on the edge that sees the access
  // phase together with the registered pready
  always_comb begin
    access = psel && penable;
    done = access && st.pready;
    mapped = (paddr == SYS_CTRL_OFS) || (paddr == SENSE_OFS) ||
             (paddr == ENABLE_OFS) || (paddr == STATUS_OFS) ||
             (paddr == PRIO_A_OFS) || (paddr == PRIO_B_OFS) ||
             (paddr == CURRENT_OFS);
    wr_done = done && pwrite && mapped;
  end

  // Read value of the addressed register; reserved bits read zero except in the sense register, which reads back all 8 bits
  always_comb begin
    rd_mux = 8'h00;
    case (paddr)
      SYS_CTRL_OFS: rd_mux = {6'h00, st.sys_ctrl};
      SENSE_OFS: rd_mux = st.sense;
      ENABLE_OFS: begin
        for (int i = 0; i < NUM_EXT; i++) begin
          rd_mux[EXT_BIT[i]] = st.enable[i];
        end
      end
      STATUS_OFS: begin
        for (int i = 0; i < NUM_EXT; i++) begin
          rd_mux[EXT_BIT[i]] = st.flag[i];
        end
      end
      PRIO_A_OFS: rd_mux = st.prio_a;
      PRIO_B_OFS: rd_mux = st.prio_b;
      CURRENT_OFS: rd_mux = {2'h0, st.vector};
      default: rd_mux = 8'h00;
    endcase
  end

  // Requests and levels offered to the picker
  // Module requests sit above the four external ones in the source table
  always_comb begin
    fwd_ext = st.flag & st.enable;
    prio_all = {st.prio_b, st.prio_a};
    rk.req = {module_req, fwd_ext};
    for (int s = 0; s < NUM_SRC; s++) begin
      rk.lvl[s] = prio_all[SRC_PRIO[s]];
    end
  end

  // Whole next-state logic
  always_comb begin
    logic clr_sw;
    logic clr_ack;
    logic edge_mode;
    clr_sw = 1'b0;
    clr_ack = 1'b0;
    edge_mode = 1'b0;
    next_st = st;

    // Pins pass two flip-flops; direction setting plays no part
    // Only the second stage feeds logic; the first may be metastable
    next_st.nmi_s1 = nmi_pin;
    next_st.nmi_s2 = st.nmi_s1;
    next_st.nmi_prev = st.nmi_s2;
    next_st.ext_s1 = ext_request_b;
    next_st.ext_s2 = st.ext_s1;
    next_st.ext_prev = st.ext_s2;

    // Non-maskable edge, rising when the select bit is one
    nmi_edge = st.sys_ctrl[EDGE_SEL_BIT] ? (st.nmi_s2 && !st.nmi_prev)
                                         : (!st.nmi_s2 && st.nmi_prev);
    // A new edge wins over the acknowledge that clears it
    next_st.nmi_pend = nmi_edge ||
                       (st.nmi_pend && !(cpu_ack && ack_vector == NMI_VEC));

    // External flags: set wins over either kind of clear
    // A low level keeps setting its flag, so a level request only goes
    // away once the pin is high again and the flag has been cleared
    for (int i = 0; i < NUM_EXT; i++) begin
      edge_mode = st.sense[EXT_BIT[i]];
      // Falling edge or low level, per the sense bit
      ext_set[i] = edge_mode ? (st.ext_prev[i] && !st.ext_s2[i]) : !st.ext_s2[i];
      // Zero written after the flag was read as one
      clr_sw = wr_done && (paddr == STATUS_OFS) && !pwdata[EXT_BIT[i]] && st.seen[i];
      // Taken by the CPU; a level request clears only once the pin is high
      clr_ack = cpu_ack && (ack_vector == SRC_VEC[i]) && (edge_mode || st.ext_s2[i]);
      next_st.flag[i] = ext_set[i] || (st.flag[i] && !clr_sw && !clr_ack);
      if (clr_sw || clr_ack) begin
        next_st.seen[i] = 1'b0;
      end else if (done && !pwrite && paddr == STATUS_OFS && st.prdata[EXT_BIT[i]]) begin
        next_st.seen[i] = 1'b1;
      end
    end

    // APB answer one cycle into the access phase
    next_st.pready = access && !st.pready;
    if (access && !st.pready) begin
      next_st.prdata = {24'h000000, rd_mux};
      next_st.pslverr = !mapped;
    end

    // Register writes take effect at the completing edge
    // Status clears are handled above; the current-vector offset is read only
    if (wr_done) begin
      case (paddr)
        SYS_CTRL_OFS: next_st.sys_ctrl = pwdata[1:0];
        SENSE_OFS: next_st.sense = pwdata[7:0];
        ENABLE_OFS: begin
          for (int i = 0; i < NUM_EXT; i++) begin
            next_st.enable[i] = pwdata[EXT_BIT[i]];
          end
        end
        PRIO_A_OFS: next_st.prio_a = pwdata[7:0] & PRIO_A_MASK;
        PRIO_B_OFS: next_st.prio_b = pwdata[7:0] & PRIO_B_MASK;
        default: next_st.sys_ctrl = st.sys_ctrl;
      endcase
    end

    // Offered request: non-maskable first, then the picker's winner
    // Registered, so the offer trails the flags by one edge and the CPU
    // never sees a vector that changes within a cycle
    if (st.nmi_pend) begin
      next_st.irq_valid = 1'b1;
      next_st.vector = NMI_VEC;
      next_st.level = 1'b1;
    end else if (rk.hit) begin
      next_st.irq_valid = 1'b1;
      next_st.vector = SRC_VEC[rk.idx];
      next_st.level = rk.lvl[rk.idx];
    end else begin
      next_st.irq_valid = 1'b0;
      next_st.vector = '0;
      next_st.level = 1'b0;
    end
    // Lower 16 address bits, two or four bytes per vector
    if (next_st.sys_ctrl[ADV_MODE_BIT]) begin
      next_st.vec_addr = {8'h00, next_st.vector, 2'h0};
    end else begin
      next_st.vec_addr = {9'h000, next_st.vector, 1'h0};
    end

    // Standby exit from the non-maskable pin and inputs 0 and 1 only
    // Built from enabled flags, so a disabled input cannot end standby
    next_st.wake = st.nmi_pend || fwd_ext[0] || fwd_ext[1];
  end

  // State register; reset gives default order and level sensing
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st <= RESET_ST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq_valid = st.irq_valid;
  assign irq_vector = st.vector;
  assign irq_vector_addr = st.vec_addr;
  assign irq_level = st.level;
  assign wake_request = st.wake;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Flag 0 read as one, then zero written to it
  sequence s_read_one;
    done && !pwrite && paddr == STATUS_OFS && st.prdata[0];
  endsequence
  sequence s_write_zero;
    wr_done && paddr == STATUS_OFS && !pwdata[0] && !ext_set[0];
  endsequence

  a_nmi_first_rank: assert property (st.nmi_pend |=> irq_valid && irq_vector == NMI_VEC)
    else $error("non-maskable request not offered first");
  a_nmi_edge_catch: assert property (nmi_edge |=> st.nmi_pend)
    else $error("non-maskable edge lost");
  a_level_sets_flag: assert property (!st.sense[0] && !st.ext_s2[0] |=> st.flag[0])
    else $error("low level did not set flag 0");
  a_fall_sets_flag: assert property (
    st.sense[4] && st.ext_prev[2] && !st.ext_s2[2] |=> st.flag[2])
    else $error("falling edge did not set flag for input 4");
  a_enable_gates_req: assert property (
    !st.nmi_pend && module_req == '0 && (st.flag & st.enable) == '0 |=> !irq_valid)
    else $error("disabled request was offered");
  a_flag_sw_clear: assert property (s_read_one ##[1:20] s_write_zero |=> !st.flag[0])
    else $error("flag 0 survived a zero write after read");
  a_vec_addr_map: assert property (
    irq_valid |-> irq_vector_addr == (st.sys_ctrl[ADV_MODE_BIT] ?
      {8'h00, irq_vector, 2'h0} : {9'h000, irq_vector, 1'h0}))
    else $error("vector address does not match vector");
  a_no_reserved_vec: assert property (irq_valid |-> vec_mapped(irq_vector))
    else $error("reserved vector number issued");
  a_wake_sources: assert property (
    wake_request |-> $past(st.nmi_pend || fwd_ext[0] || fwd_ext[1]))
    else $error("standby exit from a source that may not wake");
  a_default_order: assert property (
    !st.nmi_pend && st.prio_a == 8'h00 && st.prio_b == 8'h00 && fwd_ext[0]
    |=> irq_vector == SRC_VEC[0])
    else $error("default order not by vector number");

  // APB answer steps: access seen without pready, then a one-cycle pready
  sequence s_access_open;
    access && !st.pready;
  endsequence
  sequence s_answer_pulse;
    pready ##1 !pready;
  endsequence

  // Every access phase gets its answer after exactly one wait state
  a_apb_one_wait: assert property (s_access_open |=> s_answer_pulse)
    else $error("APB answer did not take exactly one wait state");
  // An unmapped offset is answered with an error
  a_bad_addr_err: assert property (access && !st.pready && !mapped |=> pready && pslverr)
    else $error("unmapped address answered without an error");

  // A requesting level one source always beats level zero ones
  a_level_one_wins: assert property (
    !st.nmi_pend && (rk.req & rk.lvl) != '0 |=> irq_valid && irq_level)
    else $error("level one request lost to a level zero one");
  // Taking the non-maskable vector retires its pending request
  a_nmi_ack_clear: assert property (
    st.nmi_pend && cpu_ack && ack_vector == NMI_VEC && !nmi_edge |=> !st.nmi_pend)
    else $error("taken non-maskable request still pending");
  // A status flag stands until an acknowledge or a status write
  a_flag_holds: assert property (
    st.flag[1] && !cpu_ack && !(wr_done && paddr == STATUS_OFS) |=> st.flag[1])
    else $error("flag 1 dropped without a clear");
  // Edge mode ignores a steady low level
  a_edge_no_level: assert property (
    st.sense[0] && !st.flag[0] && !(st.ext_prev[0] && !st.ext_s2[0]) |=> !st.flag[0])
    else $error("edge mode input 0 set its flag without a fall");
  // Without a waking source no standby exit is requested
  a_wake_denied: assert property (
    !st.nmi_pend && !fwd_ext[0] && !fwd_ext[1] |=> !wake_request)
    else $error("standby exit without a waking source");

  // Reset leaves default order, level sensing and clear flags
  a_reset_default: assert property (
    $rose(rst_b) |-> st.prio_a == REG_RESET && st.prio_b == REG_RESET &&
      st.sense == REG_RESET && st.flag == '0)
    else $error("reset did not restore the default settings");

endmodule

// ===== hdl/rank_if.sv
/*
  Carrier between the vectoring top and its ranking picker.
  Assumes both ends sit on the same clock; the picker is combinational.
*/
`timescale 1ns/1ps
interface rank_if;
  import vectoring_pkg::*;
  logic [NUM_SRC-1:0] req;      // Forwarded requests
  logic [NUM_SRC-1:0] lvl;      // Programmed priority level per source
  logic hit;                    // Some request is pending
  logic [SRC_IDX_W-1:0] idx;    // Winning source index

  modport picker (input req, input lvl, output hit, output idx);
  modport asker (output req, output lvl, input hit, input idx);
endinterface

// ===== hdl/source_ranker.sv
/*
  Picks the winning source: level one beats level zero, and among equals the
  lower index, which the table keeps in ascending vector order, wins.
  Assumes the source table is sorted by vector number.
*/
`timescale 1ns/1ps
module source_ranker #(
  parameter int N = vectoring_pkg::NUM_SRC
) (
  rank_if.picker rk
);
  import vectoring_pkg::*;

  // Refuse sizes that the index cannot reach
  if (N < 1 || N > (1 << SRC_IDX_W) || N > NUM_SRC) begin : g_bad_n
    $error("source_ranker: N out of range");
  end

  // Scan upward; a later source wins only with a strictly higher level
  always_comb begin
    logic best_lvl;
    best_lvl = 1'b0;
    rk.hit = 1'b0;
    rk.idx = '0;
    for (int i = 0; i < N; i++) begin
      if (rk.req[i] && (!rk.hit || (rk.lvl[i] && !best_lvl))) begin
        rk.hit = 1'b1;
        rk.idx = SRC_IDX_W'(i);
        best_lvl = rk.lvl[i];
      end
    end
  end

endmodule

// ===== hdl/vectoring_pkg.sv
/*
  Shared constants for the interrupt source and vector logic: register
  offsets, field positions, reset values, vector numbers and the source table.
  Assumes a 32-bit APB slave with word-aligned byte offsets.
*/
package vectoring_pkg;

  // Widths
  localparam int ADDR_W = 8;                 // APB byte address width
  localparam int VEC_W = 6;                  // Vector number width
  localparam int NUM_EXT = 4;                // External request pins
  localparam int NUM_INT = 25;               // On-chip module requests
  localparam int NUM_SRC = 29;               // Ranked maskable sources
  localparam int SRC_IDX_W = 5;              // Index width over the sources

  // Register byte offsets
  localparam logic [7:0] SYS_CTRL_OFS = 8'h00;      // system_control_reg
  localparam logic [7:0] SENSE_OFS = 8'h04;         // request_sense_select_reg
  localparam logic [7:0] ENABLE_OFS = 8'h08;        // request_enable_reg
  localparam logic [7:0] STATUS_OFS = 8'h0C;        // request_status_reg
  localparam logic [7:0] PRIO_A_OFS = 8'h10;        // priority_reg_a
  localparam logic [7:0] PRIO_B_OFS = 8'h14;        // priority_reg_b
  localparam logic [7:0] CURRENT_OFS = 8'h18;       // Current vector, read only

  // Field positions and masks
  localparam int EDGE_SEL_BIT = 0;                  // nonmaskable_edge_select
  localparam int ADV_MODE_BIT = 1;                  // Four-byte vector mode
  localparam logic [7:0] PRIO_A_MASK = 8'hDF;       // Writable priority A bits
  localparam logic [7:0] PRIO_B_MASK = 8'hCE;       // Writable priority B bits
  localparam int CUR_VALID_BIT = 8;                 // Unused; the current reg reads only the vector, so bit 8 is always zero
  localparam logic [NUM_EXT-1:0][2:0] EXT_BIT = {3'h5, 3'h4, 3'h1, 3'h0};

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // Vector numbers
  localparam logic [VEC_W-1:0] NMI_VEC = 6'h07;

  // Source table, index 0 first: external 0,1,4,5 then on-chip modules
  localparam logic [NUM_SRC-1:0][VEC_W-1:0] SRC_VEC = {
    6'h3C, 6'h3B, 6'h3A, 6'h39, 6'h38, 6'h37, 6'h36, 6'h35, 6'h34,
    6'h2A, 6'h29, 6'h28, 6'h26, 6'h25, 6'h24, 6'h22, 6'h21, 6'h20,
    6'h1E, 6'h1D, 6'h1C, 6'h1A, 6'h19, 6'h18, 6'h14,
    6'h11, 6'h10, 6'h0D, 6'h0C};

  // Priority bit of each source inside {priority_reg_b, priority_reg_a}
  localparam logic [NUM_SRC-1:0][3:0] SRC_PRIO = {
    4'h9, 4'hA, 4'hA, 4'hA, 4'hA, 4'hB, 4'hB, 4'hB, 4'hB,
    4'hE, 4'hE, 4'hE, 4'hF, 4'hF, 4'hF, 4'h0, 4'h0, 4'h0,
    4'h1, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3,
    4'h4, 4'h4, 4'h6, 4'h7};

  // True when a vector number belongs to a real source
  function automatic logic vec_mapped(input logic [VEC_W-1:0] v);
    logic hit;
    hit = (v == NMI_VEC);
    for (int i = 0; i < NUM_SRC; i++) begin
      if (SRC_VEC[i] == v) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

endpackage

// ===== verification/cpu_model.sv
/*
  Behavioural CPU core: takes the offered vector and pulses an acknowledge.
  Assumes irq outputs of the block are registered on core_clk.
*/
`timescale 1ns/1ps
module cpu_model (
  input logic core_clk,
  input logic rst_b,
  input logic take,
  input logic irq_valid,
  input logic [5:0] irq_vector,
  output logic cpu_ack,
  output logic [5:0] ack_vector,
  output logic [5:0] last_ack
);
  logic [2:0] gap; // Cycles left before the next acknowledge

  // Acknowledge one offer, then leave time for the block to move on
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cpu_ack <= 1'b0;
      ack_vector <= 6'h00;
      last_ack <= 6'h00;
      gap <= 3'h0;
    end else begin
      cpu_ack <= 1'b0;
      ack_vector <= ~ack_vector; // Not valid outside an acknowledge
      if (gap != 3'h0) begin
        gap <= gap - 3'h1;
      end else if (take && irq_valid) begin
        cpu_ack <= 1'b1;
        ack_vector <= irq_vector;
        last_ack <= irq_vector;
        gap <= 3'h4;
      end
    end
  end
endmodule

// ===== verification/tb.sv
/*
  Self-checking bench: APB master, pin stimulus and a ranking model.
  Assumes the CPU model in cpu_model.sv and the design package.
*/
`timescale 1ns/1ps
module tb;
  import vectoring_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic nmi_pin = 1'b1;
  logic [NUM_EXT-1:0] ext_request_b = 4'hF; // Request pins, driven as plain inputs only
  logic [NUM_INT-1:0] module_req = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic take = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_valid, irq_level, wake_request, cpu_ack;
  logic [VEC_W-1:0] irq_vector, ack_vector, last_ack;
  logic [15:0] irq_vector_addr;
  int fails = 0;
  int n_checks = 0;
  int v;
  logic [31:0] seed = 32'h56; // Xorshift state
  logic [7:0] pa = 8'h00; // Model of priority A
  logic [7:0] pb = 8'h00; // Model of priority B
  logic adv = 1'b0; // Model of vector mode
  logic [31:0] rd;
  logic er;
  int mv[25] = '{20, 24, 25, 26, 28, 29, 30, 32, 33, 34, 36, 37, 38, 40, 41, 42,
                 52, 53, 54, 55, 56, 57, 58, 59, 60};

  always #10 core_clk = ~core_clk;

  interrupt_source_vectoring u_interrupt_source_vectoring (.core_clk(core_clk), .rst_b(rst_b),
    .nmi_pin(nmi_pin), .ext_request_b(ext_request_b), .module_req(module_req),
    .cpu_ack(cpu_ack), .ack_vector(ack_vector), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_valid(irq_valid), .irq_vector(irq_vector),
    .irq_vector_addr(irq_vector_addr), .irq_level(irq_level), .wake_request(wake_request));
  cpu_model u_cpu_model (.core_clk(core_clk), .rst_b(rst_b), .take(take),
    .irq_valid(irq_valid), .irq_vector(irq_vector), .cpu_ack(cpu_ack),
    .ack_vector(ack_vector), .last_ack(last_ack));

  // Pseudo-random words
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Programmed level of a vector from the modelled priority registers
  function automatic int lvl(int vn);
    int b;
    case (vn) inside
      12: b = 7;
      13: b = 6;
      [16:17]: b = 4;
      20: b = 3;
      [24:26]: b = 2;
      [28:30]: b = 1;
      [32:34]: b = 0;
      [36:38]: b = 15;
      [40:42]: b = 14;
      [52:55]: b = 11;
      [56:59]: b = 10;
      default: b = 9;
    endcase
    return ({pb, pa} >> b) & 1;
  endfunction

  // Winner among module requests: higher level, then smaller vector
  function automatic int best(logic [NUM_INT-1:0] m);
    int b = 0;
    int bl = -1;
    for (int i = 0; i < 25; i++) begin
      if (m[i] && lvl(mv[i]) > bl) begin
        bl = lvl(mv[i]);
        b = mv[i];
      end
    end
    return b;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Offered request against the model
  task automatic out_chk(input int vn, input int l);
    chk(irq_valid, vn != 0);
    chk(irq_vector, vn);
    chk(irq_vector_addr, adv ? vn * 4 : vn * 2);
    chk(irq_level, l);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic close_out();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (6000) @(posedge core_clk);
    fails++;
    close_out();
  end

  // Main sequence
  initial begin
    cyc(2);
    rst_b <= 1'b1;
    cyc(1);
    for (int a = 0; a <= 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    out_chk(0, 0);
    // Random module traffic, default then programmed order
    for (int i = 0; i < 16; i++) begin
      if (i == 4) begin
        apb(1'b1, SYS_CTRL_OFS, 32'h2);
        adv = 1'b1;
      end
      if (i >= 8) begin
        pa = 8'(xs());
        pb = 8'(xs());
        apb(1'b1, PRIO_A_OFS, {24'h0, pa});
        apb(1'b1, PRIO_B_OFS, {24'h0, pb});
        pa &= PRIO_A_MASK;
        pb &= PRIO_B_MASK;
        apb(1'b0, PRIO_A_OFS, 32'h0);
        chk(rd, pa);
      end
      module_req <= 25'(xs() & xs() & xs());
      cyc(4);
      v = best(module_req);
      out_chk(v, v != 0 ? lvl(v) : 0);
      apb(1'b0, CURRENT_OFS, 32'h0);
      chk(rd, v);
    end
    module_req <= '0;
    pa = 8'h00;
    pb = 8'h00;
    apb(1'b1, PRIO_A_OFS, 32'h0);
    apb(1'b1, PRIO_B_OFS, 32'h0);
    apb(1'b1, SENSE_OFS, 32'h1);
    apb(1'b1, ENABLE_OFS, 32'h12);
    // Level sensing on inputs 1 and 4
    ext_request_b <= 4'b1101;
    cyc(6);
    out_chk(13, 0);
    chk(wake_request, 1'b1);
    ext_request_b <= 4'b1011;
    cyc(6);
    out_chk(13, 0);
    pa = 8'h10;
    apb(1'b1, PRIO_A_OFS, 32'h10);
    cyc(2);
    out_chk(16, 1);
    pa = 8'h00;
    apb(1'b1, PRIO_A_OFS, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, 32'h12);
    apb(1'b1, STATUS_OFS, 32'h10);
    cyc(2);
    out_chk(16, 0);
    chk(wake_request, 1'b0);
    ext_request_b <= 4'b1111;
    cyc(4);
    apb(1'b0, STATUS_OFS, 32'h0);
    apb(1'b1, STATUS_OFS, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    // Edge sensing on input 0 while disabled
    ext_request_b <= 4'b1110;
    cyc(4);
    ext_request_b <= 4'b1111;
    cyc(4);
    out_chk(0, 0);
    apb(1'b1, STATUS_OFS, 32'h0);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, ENABLE_OFS, 32'h13);
    cyc(2);
    out_chk(12, 0);
    chk(wake_request, 1'b1);
    apb(1'b1, STATUS_OFS, 32'h0);
    cyc(2);
    out_chk(0, 0);
    // Non-maskable source over a level one request
    pa = PRIO_A_MASK;
    apb(1'b1, PRIO_A_OFS, 32'hFF);
    module_req <= 25'h1;
    nmi_pin <= 1'b0;
    cyc(6);
    out_chk(7, 1);
    chk(wake_request, 1'b1);
    take <= 1'b1;
    cyc(1);
    take <= 1'b0;
    cyc(7);
    chk(last_ack, 6'h07);
    out_chk(20, 1);
    apb(1'b1, SYS_CTRL_OFS, 32'h3);
    nmi_pin <= 1'b1;
    cyc(6);
    out_chk(7, 1);
    take <= 1'b1;
    cyc(8);
    take <= 1'b0;
    nmi_pin <= 1'b0;
    cyc(6);
    out_chk(20, 1);
    close_out();
  end
endmodule
